// ==== hdl/tap_delay_line.sv ====
// Top of the per-pin programmable tap delay line.
// Assumes fabric drives step_en, up_dn and mod_rst synchronous to clock.
//
// Notes on behaviour
// - Sixty-four tap positions; position wraps instead of saturating.
// - Delays the input path, the output path, or both of one pin.
// - Zero-hold default input mode uses a built-in tap, no calibration.
// - Fixed input mode loads the input preset at configuration and holds it.
// - Variable input mode lets step_en and up_dn move the tap later.
// - Output delay is fixed only, taken from the output preset.
// - Bidirectional configuration alternates delay between input and output paths.
// - Bidirectional fixed/fixed presets both taps; neither changes afterwards.
// - Bidirectional variable/fixed adjusts only the input tap.
// - Bidirectional source is pad_in when tri_ctrl high, out_path_in when low.
// - Fabric source allows fixed and variable only, never zero-hold default.
// - delayed_out carries exactly one of the three data inputs.
// - Module reset returns the tap positions to their presets; in zero-hold default the input tap returns to the built-in tap.
// - The clock times the tap adjustment controls in variable mode.
// - Every delay data, control and clock pin is one bit wide; the register port addr, wdata and rdata are wider.
// - step_en gates adjustment; up_dn picks the direction; fabric drives both.
// - Step up from 63 gives 0; step down from 0 gives 63.
// - While step_en is high in variable mode the input tap moves one per clock.
// - Module reset is active high, synchronous, and beats step_en and up_dn.
// - An unset preset means zero taps.
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/100ps
module tap_delay_line
    import tap_delay_pkg::*;
(
    input wire logic clock, // System clock, 50 MHz
    input wire logic rst_n, // Synchronous reset, active low
    input wire tap_delay_pkg::addr_t addr, // Register address
    input wire tap_delay_pkg::data_t wdata, // Register write data
    input wire logic wr_en, // Register write strobe
    input wire logic rd_en, // Register read strobe
    output tap_delay_pkg::data_t rdata, // Read data, cycle after rd_en
    input wire logic pad_in, // Data from the pad
    input wire logic out_path_in, // Data from the output logic
    input wire logic fabric_in, // Data from fabric logic
    input wire logic tri_ctrl, // Direction, high selects the input path
    input wire logic step_en, // Enable one tap move per clock
    input wire logic up_dn, // High steps up, low steps down
    input wire logic mod_rst, // Module reset, active high
    output logic delayed_out, // Delayed data
    output logic calib_required // Calibration controller needed
);

    // -------------------------------------------------------------
    // Configuration register
    // -------------------------------------------------------------
    logic [CFG_W-1:0] cfg;
    logic cfg_loaded;
    wire cfg_hit = wr_en && (addr == CFG_ADDR);
    wire stat_hit = addr == STAT_ADDR;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cfg <= CFG_RESET;
            cfg_loaded <= 1'b0;
        end else begin
            if (cfg_hit) begin
                cfg <= wdata[CFG_W-1:0];
            end
            cfg_loaded <= cfg_hit;
        end
    end

    // -------------------------------------------------------------
    // Mode decode
    // -------------------------------------------------------------
    delay_src_t src_mode;
    in_kind_t kind_raw;
    in_kind_t kind_eff;
    tap_t in_preset;
    tap_t out_preset;
    tap_t in_load_value;
    logic fabric_sel;
    logic out_only;
    logic bidir;

    assign src_mode = delay_src_t'(cfg[CFG_SRC_LSB +: 2]);
    assign kind_raw = in_kind_t'(cfg[CFG_KIND_LSB +: 2]);
    assign in_preset = cfg[CFG_IPRE_LSB +: TAP_W];
    assign out_preset = cfg[CFG_OPRE_LSB +: TAP_W];
    assign fabric_sel = src_mode == SRC_FABRIC;
    assign out_only = src_mode == SRC_OUT;
    assign bidir = src_mode == SRC_BIDIR;

    // Zero-hold default only exists on the pad-only path; elsewhere it falls back to fixed
    assign kind_eff = (kind_raw == KIND_SPARE) ? KIND_FIXED
                    : (kind_raw == KIND_DEFAULT && src_mode != SRC_PAD) ? KIND_FIXED
                    : kind_raw;

    // Default mode uses the built-in hold tap instead of the preset
    assign in_load_value = (kind_eff == KIND_DEFAULT) ? DEFAULT_HOLD_TAPS : in_preset;

    // Calibration only unneeded in zero-hold default mode
    assign calib_required = kind_eff != KIND_DEFAULT;

    // -------------------------------------------------------------
    // Tap position counters
    // -------------------------------------------------------------
    logic tap_load;
    logic var_en;
    logic in_step;
    tap_t in_tap;
    tap_t out_tap;

    // Reset, module reset and a fresh configuration all reload the presets
    assign tap_load = !rst_n || mod_rst || cfg_loaded;
    // Only the input path of a variable mode may move; the output tap never does
    assign var_en = (kind_eff == KIND_VARIABLE) && !out_only;
    assign in_step = var_en && step_en;

    tap_counter in_counter (
        .clock(clock),
        .load(tap_load),
        .preset(in_load_value),
        .step(in_step),
        .up(up_dn),
        .tap(in_tap)
    );

    tap_counter out_counter (
        .clock(clock),
        .load(tap_load),
        .preset(out_preset),
        .step(1'b0),
        .up(1'b0),
        .tap(out_tap)
    );

    // -------------------------------------------------------------
    // Source and tap selection
    // -------------------------------------------------------------
    logic use_in_path;
    logic sel_src;
    tap_t active_tap;

    // Bidirectional mode follows the direction pin every cycle
    assign use_in_path = !out_only && !(bidir && !tri_ctrl);
    assign active_tap = use_in_path ? in_tap : out_tap;

    always_comb begin
        case (src_mode)
            SRC_PAD: sel_src = pad_in;
            SRC_OUT: sel_src = out_path_in;
            SRC_BIDIR: sel_src = tri_ctrl ? pad_in : out_path_in;
            SRC_FABRIC: sel_src = fabric_in;
            default: sel_src = pad_in;
        endcase
    end

    delay_chain chain (
        .clock(clock),
        .rst_n(rst_n),
        .src(sel_src),
        .tap(active_tap),
        .delayed_out(delayed_out)
    );

    // -------------------------------------------------------------
    // Register read
    // -------------------------------------------------------------
    data_t stat_word;
    data_t cfg_word;
    data_t read_word;

    always_comb begin
        stat_word = DATA_ZERO;
        stat_word[STAT_ITAP_LSB +: TAP_W] = in_tap;
        stat_word[STAT_OTAP_LSB +: TAP_W] = out_tap;
        stat_word[STAT_DIR_BIT] = use_in_path;
        stat_word[STAT_CAL_BIT] = calib_required;
        stat_word[STAT_ADJ_BIT] = var_en;
    end

    assign cfg_word = {{(DATA_W-CFG_W){1'b0}}, cfg};
    assign read_word = (addr == CFG_ADDR) ? cfg_word : (stat_hit ? stat_word : DATA_ZERO);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata <= DATA_ZERO;
        end else if (rd_en) begin
            rdata <= read_word;
        end else begin
            rdata <= DATA_ZERO;
        end
    end

    // -------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    logic past_valid;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            past_valid <= 1'b0;
        end else begin
            past_valid <= 1'b1;
        end
    end

    wrap_up_a: assert property (
        in_step && up_dn && !tap_load && in_tap == TAP_LAST |=> in_tap == TAP_ZERO)
        else $error("tap did not wrap from 63 to 0");

    wrap_down_a: assert property (
        in_step && !up_dn && !tap_load && in_tap == TAP_ZERO |=> in_tap == TAP_LAST)
        else $error("tap did not wrap from 0 to 63");

    step_move_a: assert property (
        var_en && step_en && !tap_load |=> in_tap == tap_step($past(in_tap), $past(up_dn)))
        else $error("tap did not move one step");

    no_step_hold_a: assert property (
        !step_en && !tap_load |=> $stable(in_tap))
        else $error("tap moved without step enable");

    fixed_hold_a: assert property (
        kind_eff == KIND_FIXED && !tap_load |=> $stable(in_tap))
        else $error("fixed input tap changed");

    out_hold_a: assert property (
        !tap_load |=> $stable(out_tap))
        else $error("output tap changed after configuration");

    mod_reset_a: assert property (
        mod_rst |=> in_tap == $past(in_load_value) && out_tap == $past(out_preset))
        else $error("module reset did not reload presets");

    default_tap_a: assert property (
        past_valid && kind_eff == KIND_DEFAULT && !cfg_loaded |-> in_tap == DEFAULT_HOLD_TAPS)
        else $error("default mode tap wrong");

    fabric_kind_a: assert property (
        fabric_sel |-> kind_eff != KIND_DEFAULT && sel_src == fabric_in)
        else $error("fabric source in default mode");

    bidir_path_a: assert property (
        bidir |-> (tri_ctrl ? (sel_src == pad_in && active_tap == in_tap)
                            : (sel_src == out_path_in && active_tap == out_tap)))
        else $error("bidirectional path selection wrong");

    zero_tap_a: assert property (
        past_valid && active_tap == TAP_ZERO |=> delayed_out == $past(sel_src))
        else $error("tap zero output not one cycle behind source");

    read_late_a: assert property (
        rd_en && stat_hit |=> rdata[STAT_ITAP_LSB +: TAP_W] == $past(in_tap))
        else $error("status read wrong");

    // -------------------------------------------------------------
    // Path, reload and register port assertions
    // -------------------------------------------------------------
    pad_source_a: assert property (
        src_mode == SRC_PAD |-> sel_src == pad_in && active_tap == in_tap)
        else $error("pad source or tap wrong");

    out_path_a: assert property (
        out_only |-> sel_src == out_path_in && active_tap == out_tap)
        else $error("output path source or tap wrong");

    dir_follow_a: assert property (
        bidir |-> use_in_path == tri_ctrl)
        else $error("path does not follow direction");

    fabric_tap_a: assert property (
        fabric_sel |-> active_tap == in_tap)
        else $error("fabric source not on input tap");

    default_pad_a: assert property (
        kind_eff == KIND_DEFAULT |-> src_mode == SRC_PAD && !calib_required)
        else $error("default mode outside pad source");

    bidir_fixed_hold_a: assert property (
        bidir && kind_eff == KIND_FIXED && !tap_load |=> $stable(in_tap) && $stable(out_tap))
        else $error("bidirectional fixed tap changed");

    bidir_var_out_a: assert property (
        bidir && kind_eff == KIND_VARIABLE && !tap_load |=> $stable(out_tap))
        else $error("output tap moved in variable mode");

    out_only_hold_a: assert property (
        out_only && !tap_load |=> $stable(in_tap))
        else $error("input tap moved in output mode");

    step_change_a: assert property (
        in_step && !tap_load |=> in_tap != $past(in_tap))
        else $error("step left tap unchanged");

    step_up_one_a: assert property (
        in_step && up_dn && !tap_load |=> in_tap == tap_t'($past(in_tap) + TAP_ONE))
        else $error("step up not one tap");

    step_down_one_a: assert property (
        in_step && !up_dn && !tap_load |=> in_tap == tap_t'($past(in_tap) - TAP_ONE))
        else $error("step down not one tap");

    reset_beats_step_a: assert property (
        mod_rst && step_en |=> in_tap == $past(in_load_value))
        else $error("step beat module reset");

    cfg_reload_a: assert property (
        cfg_loaded |=> in_tap == $past(in_load_value) && out_tap == $past(out_preset))
        else $error("configuration did not reload taps");

    cfg_pulse_a: assert property (
        cfg_hit |=> cfg_loaded)
        else $error("configuration write not followed by reload");

    cfg_hold_a: assert property (
        !cfg_hit |=> $stable(cfg))
        else $error("configuration changed without write");

    wr_ignored_a: assert property (
        wr_en && addr != CFG_ADDR |=> $stable(cfg))
        else $error("write to other address changed configuration");

    rd_idle_zero_a: assert property (
        !rd_en |=> rdata == DATA_ZERO)
        else $error("read data not zero when idle");

    cfg_read_a: assert property (
        rd_en && addr == CFG_ADDR |=> rdata == $past(cfg_word))
        else $error("configuration read wrong");

    stat_read_a: assert property (
        rd_en && stat_hit |=> rdata == $past(stat_word))
        else $error("status word read wrong");

    unmapped_read_a: assert property (
        rd_en && addr != CFG_ADDR && !stat_hit |=> rdata == DATA_ZERO)
        else $error("unmapped read not zero");

    chain_delay_a: assert property (
        past_valid && active_tap == TAP_ONE |=> delayed_out == $past(sel_src, 2))
        else $error("tap one output not two cycles behind source");

    step_up_c: cover property (in_step && up_dn ##1 in_step && up_dn);
    wrap_c: cover property (in_step && !up_dn && in_tap == TAP_ZERO);
    bidir_turn_c: cover property (bidir && tri_ctrl ##1 bidir && !tri_ctrl);
    cfg_write_c: cover property (cfg_hit ##1 cfg_loaded);
    reset_step_c: cover property (mod_rst && in_step);

endmodule

// ==== hdl/tap_delay_pkg.sv ====
// Shared constants, field layout and types for the tap delay line.
// Assumes a single 50 MHz clock and a plain register port.
package tap_delay_pkg;

    // -------------------------------------------------------------
    // Tap geometry
    // -------------------------------------------------------------
    localparam int TAP_W = 6;
    localparam int TAP_COUNT = 64;
    typedef logic [TAP_W-1:0] tap_t;
    localparam tap_t TAP_ZERO = 6'h00;
    localparam tap_t TAP_LAST = 6'h3f;
    localparam tap_t TAP_ONE = 6'h01;
    // Tap used by the zero-hold default mode; arbitrary plain value
    localparam tap_t DEFAULT_HOLD_TAPS = 6'h08;

    // -------------------------------------------------------------
    // Modes
    // -------------------------------------------------------------
    typedef enum logic [1:0] {SRC_PAD, SRC_OUT, SRC_BIDIR, SRC_FABRIC} delay_src_t;
    typedef enum logic [1:0] {KIND_DEFAULT, KIND_FIXED, KIND_VARIABLE, KIND_SPARE} in_kind_t;

    // -------------------------------------------------------------
    // Register port
    // -------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    typedef logic [ADDR_W-1:0] addr_t;
    typedef logic [DATA_W-1:0] data_t;
    localparam addr_t CFG_ADDR = 8'h00;
    localparam addr_t STAT_ADDR = 8'h04;
    localparam int CFG_W = 16;
    localparam logic [CFG_W-1:0] CFG_RESET = 16'h0000;
    localparam int CFG_SRC_LSB = 0;
    localparam int CFG_KIND_LSB = 2;
    localparam int CFG_IPRE_LSB = 4;
    localparam int CFG_OPRE_LSB = 10;
    localparam int STAT_ITAP_LSB = 0;
    localparam int STAT_OTAP_LSB = 6;
    localparam int STAT_DIR_BIT = 12;
    localparam int STAT_CAL_BIT = 13;
    localparam int STAT_ADJ_BIT = 14;
    localparam data_t DATA_ZERO = 32'h0000_0000;

    // Wrapping single-tap step
    function automatic tap_t tap_step(input tap_t t, input logic up);
        return up ? tap_t'(t + TAP_ONE) : tap_t'(t - TAP_ONE);
    endfunction

endpackage

// ==== hdl/tap_counter.sv ====
// Six-bit modulo tap position counter.
// Assumes load has priority over step and covers every reset source.
`timescale 1ns/100ps
module tap_counter
    import tap_delay_pkg::*;
(
    input wire logic clock, // System clock
    input wire logic load, // Load preset this edge
    input wire tap_delay_pkg::tap_t preset, // Value taken on load
    input wire logic step, // Move one tap
    input wire logic up, // Direction of the move
    output tap_delay_pkg::tap_t tap // Current position
);

    tap_t next_tap;

    assign next_tap = load ? preset : (step ? tap_step(tap, up) : tap);

    always_ff @(posedge clock) begin
        tap <= next_tap;
    end

endmodule

// ==== hdl/delay_chain.sv ====
// Clocked model of the 64-position delay chain.
// Assumes one tap equals one clock; tap n gives n+1 cycles of latency.
`timescale 1ns/100ps
module delay_chain
    import tap_delay_pkg::*;
(
    input wire logic clock, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic src, // Selected data source
    input wire tap_delay_pkg::tap_t tap, // Active tap position
    output logic delayed_out // Delayed data
);

    logic [TAP_COUNT-2:0] stage;
    tap_t tap_less;
    logic next_out;

    assign tap_less = tap_t'(tap - TAP_ONE);
    assign next_out = (tap == TAP_ZERO) ? src : stage[tap_less];

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stage <= '0;
            delayed_out <= 1'b0;
        end else begin
            stage <= {stage[TAP_COUNT-3:0], src};
            delayed_out <= next_out;
        end
    end

endmodule

// ==== tb/fabric_ctrl.sv ====
// Fabric-side model that drives the tap adjustment controls.
// Assumes one clock shared with the delay line; controls change after rising edges.
`timescale 1ns/100ps
module fabric_ctrl (
    input wire logic clock, // System clock
    output logic step_en, // Step enable
    output logic up_dn, // Step direction
    output logic mod_rst // Module reset, active high
);
    initial begin
        step_en = 1'b0;
        up_dn = 1'b0;
        mod_rst = 1'b0;
    end

    // -------------------------------------------------------------
    // Step burst; gap idle cycles between steps models slow fabric
    // -------------------------------------------------------------
    task automatic steps(input int n, input logic dir, input logic rst, input int gap);
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            step_en <= 1'b1;
            up_dn <= dir;
            mod_rst <= rst;
            for (int g = 0; g < gap; g++) begin
                @(posedge clock);
                step_en <= 1'b0;
                up_dn <= ~dir;
            end
        end
        @(posedge clock);
        step_en <= 1'b0;
        // Direction is meaningless while idle, so it does not hold the old value
        up_dn <= ~dir;
        mod_rst <= 1'b0;
    endtask
endmodule

// ==== tb/tb_tap_delay_line.sv ====
// Self-checking bench for the tap delay line.
// Assumes the fabric model drives step controls and the bench owns the register port.
`timescale 1ns/100ps
module tb_tap_delay_line;
    import tap_delay_pkg::*;

    logic clock = 1'b0;
    logic rst_n = 1'b0;
    addr_t addr = 8'h00;
    data_t wdata = 32'h0000_0000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    data_t rdata;
    logic [2:0] din = 3'h0;
    logic tri_sel = 1'b1;
    logic step_en, up_dn, mod_rst, delayed_out, calib_required;
    int err_count = 0;
    int total_checks = 0;

    initial begin
        forever #10 clock = ~clock;
    end

    tap_delay_line tap_delay_line_i (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .pad_in(din[0]), .out_path_in(din[1]),
        .fabric_in(din[2]), .tri_ctrl(tri_sel), .step_en(step_en), .up_dn(up_dn),
        .mod_rst(mod_rst), .delayed_out(delayed_out), .calib_required(calib_required));
    fabric_ctrl fabric_ctrl_i (.clock(clock), .step_en(step_en), .up_dn(up_dn), .mod_rst(mod_rst));

    // -------------------------------------------------------------
    // Access and compare tasks
    // -------------------------------------------------------------
    task automatic chk(input string name, input data_t exp, input data_t got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic reg_wr(input addr_t a, input data_t d);
        @(posedge clock);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr_en <= 1'b0;
        @(posedge clock);
    endtask

    task automatic reg_rd(input addr_t a, output data_t d);
        @(posedge clock);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask

    // Status compare skips the path-active bit (bit 12) in every mode
    task automatic stat(input tap_t it, input tap_t ot, input logic cal, input logic adj);
        data_t d;
        reg_rd(STAT_ADDR, d);
        chk("status", {18'h0, adj, cal, ot, it}, {18'h0, d[14:13], d[11:0]});
        chk("calib_required", {31'h0, cal}, {31'h0, calib_required});
    endtask

    // Pulse inputs in mask m for one cycle; return first cycle seen high and high count
    task automatic probe(input logic [2:0] m, output int k, output int hits);
        k = 0;
        hits = 0;
        @(posedge clock);
        din <= m;
        for (int i = 1; i <= 80; i++) begin
            @(posedge clock);
            din <= 3'h0;
            #1;
            if (delayed_out === 1'b1) begin
                hits++;
                if (k == 0) k = i;
            end
        end
    endtask

    task automatic src_chk(input data_t cfg, input logic t, input logic [2:0] sel, input int lat);
        int k, hits;
        data_t d;
        reg_wr(CFG_ADDR, cfg);
        reg_rd(CFG_ADDR, d);
        chk("config", cfg, d);
        repeat (80) @(posedge clock);
        tri_sel <= t;
        probe(~sel, k, hits);
        chk("unselected", 32'h0, data_t'(hits));
        probe(sel, k, hits);
        chk("latency", data_t'(lat), data_t'(k));
        chk("width", 32'h1, data_t'(hits));
    endtask

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // -------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------
    initial begin
        data_t d;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        reg_rd(CFG_ADDR, d);
        chk("config reset", 32'h0, d);
        stat(DEFAULT_HOLD_TAPS, TAP_ZERO, 1'b0, 1'b0);
        reg_wr(8'h08, 32'h0000_ffff);
        reg_rd(8'h08, d);
        chk("unmapped", 32'h0, d);
        reg_wr(STAT_ADDR, 32'h0000_7fff);
        stat(DEFAULT_HOLD_TAPS, TAP_ZERO, 1'b0, 1'b0);
        $display("test reset done");

        reg_wr(CFG_ADDR, 32'hbeef_0054);
        reg_rd(CFG_ADDR, d);
        chk("config upper", 32'h0000_0054, d);
        fabric_ctrl_i.steps(4, 1'b1, 1'b0, 0);
        stat(6'h05, TAP_ZERO, 1'b1, 1'b0);
        $display("test fixed done");

        reg_wr(CFG_ADDR, 32'h0000_1fe8);
        fabric_ctrl_i.steps(2, 1'b1, 1'b0, 0);
        stat(TAP_ZERO, 6'h07, 1'b1, 1'b1);
        fabric_ctrl_i.steps(1, 1'b0, 1'b0, 3);
        stat(TAP_LAST, 6'h07, 1'b1, 1'b1);
        fabric_ctrl_i.steps(3, 1'b1, 1'b1, 0);
        stat(6'h3e, 6'h07, 1'b1, 1'b1);
        $display("test variable done");

        reg_wr(CFG_ADDR, 32'h0000_0ca9);
        fabric_ctrl_i.steps(3, 1'b1, 1'b0, 0);
        stat(6'h0a, 6'h03, 1'b1, 1'b0);
        reg_wr(CFG_ADDR, 32'h0000_101a);
        tri_sel <= 1'b1;
        fabric_ctrl_i.steps(2, 1'b0, 1'b0, 1);
        stat(TAP_LAST, 6'h04, 1'b1, 1'b1);
        reg_wr(CFG_ADDR, 32'h0000_0866);
        fabric_ctrl_i.steps(2, 1'b0, 1'b0, 0);
        stat(6'h06, 6'h02, 1'b1, 1'b0);
        $display("test bidirectional taps done");

        src_chk(32'h0000_002c, 1'b1, 3'h1, 3);
        src_chk(32'h0000_0000, 1'b1, 3'h1, 9);
        src_chk(32'h0000_1401, 1'b1, 3'h2, 6);
        src_chk(32'h0000_1c36, 1'b1, 3'h1, 4);
        src_chk(32'h0000_1c36, 1'b0, 3'h2, 8);
        src_chk(32'h0000_0043, 1'b1, 3'h4, 5);
        stat(6'h04, TAP_ZERO, 1'b1, 1'b0);
        $display("test data path done");
        wrap_up();
    end
endmodule
